/* File: design/bwt_pkg.sv */
// Constants and types shared by the board watchdog timer
//==============================================================
// Contract
// - Sixteen selectable timeout periods from 125 ms up to 4096 s.
// - Two-bit mode field picks timer only, reset, interrupt or dual stage.
// - Disabled after power-on; no countdown, interrupt or reset until enabled.
// - Once enabled, disable and mode changes are ignored until power cycle.
// - Writing one to retrigger restarts the countdown from the full period.
// - Every expiry sets the timeout flag, whatever the mode.
// - Timer-only expiry just sets flag; resume by clearing flag then retrigger.
// - Flag clears only on power cycle or write of one, not hard reset.
// - Reset mode expiry asserts a hard reset.
// - Interrupt mode expiry raises an interrupt without resetting the system.
// - Dual stage first expiry raises interrupt and restarts the countdown itself.
// - Dual stage second unserviced expiry, same period, asserts hard reset.
// - Dual stage retrigger after first expiry cancels second stage.
// - Carrier output line asserts on missed servicing, at first or second stage.
// - Carrier line stays asserted until a reset, then deasserts itself.
package bwt_pkg;
	//==============================================================
	// Register map and fields
	localparam int          ADDR_W     = 12;
	localparam int          DATA_W     = 32;
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STAT   = 12'h004;
	localparam logic [11:0] OFS_MASK   = 12'h008;
	localparam logic [11:0] OFS_LEFT   = 12'h00c;
	localparam int          SEL_LO     = 0;
	localparam int          SEL_W      = 4;
	localparam int          MODE_LO    = 4;
	localparam int          EN_BIT     = 6;
	localparam int          LINE_BIT   = 7;
	localparam int          RETRIG_BIT = 8;
	localparam int          FLAG_BIT   = 0;
	localparam int          IRQB_BIT   = 1;
	localparam int          STAGE_LO   = 4;
	localparam logic [1:0]  MASK_RST   = 2'h2;
	localparam logic [3:0]  SEL_RST    = 4'h0;
	//==============================================================
	// Timing
	localparam longint      CLK_NS      = 20;
	localparam longint      BASE_NS     = 125000000;
	localparam int          BASE_CYCLES = int'((BASE_NS + CLK_NS - 1) / CLK_NS);
	localparam longint      HRST_NS     = 1000;
	localparam int          HRST_CYCLES = int'((HRST_NS + CLK_NS - 1) / CLK_NS);
	//==============================================================
	// Types
	typedef enum logic [1:0] {
		BWT_TIMER = 2'h0,
		BWT_RESET = 2'h1,
		BWT_IRQ   = 2'h2,
		BWT_DUAL  = 2'h3
	} bwt_mode_t;
	typedef enum logic [2:0] {
		ST_OFF    = 3'h0,
		ST_COUNT  = 3'h1,
		ST_SECOND = 3'h2,
		ST_HALT   = 3'h3,
		ST_HRST   = 3'h4
	} bwt_stage_t;
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} bwt_apb_req_t;
	typedef struct packed {
		logic              pready;
		logic [DATA_W-1:0] prdata;
		logic              pslverr;
	} bwt_apb_rsp_t;
endpackage

/* File: design/bwt_top.sv */
// Board watchdog timer with APB register access
`timescale 1ns/1ps
module bwt_top #(
	parameter int BASE_CYC = bwt_pkg::BASE_CYCLES,
	parameter int HRST_CYC = bwt_pkg::HRST_CYCLES,
	parameter int PRE_W    = 23,
	parameter int TICK_W   = 16
) (
	// Clock, reset, enable
	input  wire logic                  i_core_clk,
	input  wire logic                  i_reset,
	input  wire logic                  i_clk_en,
	// Register bus
	input  wire bwt_pkg::bwt_apb_req_t i_apb,
	output bwt_pkg::bwt_apb_rsp_t      o_apb,
	// System
	input  wire logic                  i_sys_reset,
	output logic                       o_hard_reset,
	output logic                       o_irq,
	output logic                       o_wdt_line
);
	import bwt_pkg::*;

	//==============================================================
	// State
	typedef struct packed {
		bwt_stage_t        stage;
		logic [SEL_W-1:0]  sel;
		bwt_mode_t         mode;
		logic              en;
		logic              line_sel;
		logic              flag;
		logic              irq_ev;
		logic [1:0]        mask;
		logic [PRE_W-1:0]  pre;
		logic [TICK_W-1:0] ticks;
		logic [15:0]       hrst;
		logic              line;
		logic [DATA_W-1:0] prdata;
		logic              slverr;
	} bwt_state_t;

	bwt_state_t s;
	bwt_state_t next_s;

	//==============================================================
	// Helpers
	// Last tick index of the selected period: 2**sel ticks of 125 ms
	function automatic logic [TICK_W-1:0] last_tick(input logic [SEL_W-1:0] sel);
		logic [TICK_W-1:0] one;
		one = {{(TICK_W-1){1'b0}}, 1'b1};
		last_tick = (one << sel) - one;
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == OFS_CTRL) || (a == OFS_STAT) ||
			(a == OFS_MASK) || (a == OFS_LEFT);
	endfunction

	//==============================================================
	// Decode
	logic setup;
	logic acc_wr;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic retrig;
	logic counting;
	logic tick;
	logic expire;
	logic clr_flag;
	logic clr_irq;

	assign setup    = i_apb.psel & ~i_apb.penable;
	assign acc_wr   = i_apb.psel & i_apb.penable & i_apb.pwrite;
	assign wr_ctrl  = acc_wr & (i_apb.paddr == OFS_CTRL);
	assign wr_stat  = acc_wr & (i_apb.paddr == OFS_STAT);
	assign wr_mask  = acc_wr & (i_apb.paddr == OFS_MASK);
	assign clr_flag = wr_stat & i_apb.pwdata[FLAG_BIT];
	assign clr_irq  = wr_stat & i_apb.pwdata[IRQB_BIT];
	// Retrigger is ignored while off and while driving a hard reset
	assign retrig   = wr_ctrl & i_apb.pwdata[RETRIG_BIT] & s.en & (s.stage != ST_HRST);
	assign counting = (s.stage == ST_COUNT) || (s.stage == ST_SECOND);
	assign tick     = counting && (s.pre == PRE_W'(BASE_CYC - 1));
	assign expire   = tick && (s.ticks == last_tick(s.sel));

	//==============================================================
	// Next state
	always_comb begin
		next_s = s;

		// Prescaler and tick counter
		if (counting) begin
			next_s.pre = tick ? '0 : s.pre + PRE_W'(1);
			if (tick) begin
				next_s.ticks = expire ? '0 : s.ticks + TICK_W'(1);
			end
		end

		// Board reset clears the carrier line; a fresh expiry in the same cycle still sets it
		if (i_sys_reset) begin
			next_s.line = 1'b0;
		end

		// Expiry handling
		if (expire) begin
			case (s.mode)
				BWT_TIMER: begin
					next_s.stage = ST_HALT;
				end
				BWT_IRQ: begin
					next_s.stage = ST_HALT;
					next_s.irq_ev = 1'b1;
				end
				BWT_RESET: begin
					next_s.stage = ST_HRST;
					next_s.hrst = '0;
				end
				BWT_DUAL: begin
					if (s.stage == ST_COUNT) begin
						next_s.stage = ST_SECOND;
						next_s.irq_ev = 1'b1;
					end else begin
						next_s.stage = ST_HRST;
						next_s.hrst = '0;
					end
				end
				default: begin
					next_s.stage = ST_HALT;
				end
			endcase
			// Carrier line: first stage on any expiry, second only with reset
			if (!s.line_sel || next_s.stage == ST_HRST) begin
				next_s.line = 1'b1;
			end
		end

		// Hard reset pulse; our own state survives it, flag included
		if (s.stage == ST_HRST) begin
			if (s.hrst == 16'(HRST_CYC - 1)) begin
				next_s.stage = ST_COUNT;
				next_s.pre = '0;
				next_s.ticks = '0;
				next_s.line = 1'b0;
			end else begin
				next_s.hrst = s.hrst + 16'h1;
			end
		end

		// Control register
		if (wr_ctrl) begin
			next_s.sel = i_apb.pwdata[SEL_LO +: SEL_W];
			next_s.line_sel = i_apb.pwdata[LINE_BIT];
			// Mode and enable lock once set; taken together from one write
			if (!s.en) begin
				next_s.mode = bwt_mode_t'(i_apb.pwdata[MODE_LO +: 2]);
				next_s.en = i_apb.pwdata[EN_BIT];
				if (i_apb.pwdata[EN_BIT]) begin
					next_s.stage = ST_COUNT;
					next_s.pre = '0;
					next_s.ticks = '0;
				end
			end
		end

		// Retrigger beats a simultaneous expiry for stage, count and line; the flag and interrupt event below are still set
		if (retrig) begin
			if (s.stage != ST_HALT || !s.flag) begin
				next_s.stage = ST_COUNT;
				next_s.pre = '0;
				next_s.ticks = '0;
				next_s.line = s.line & ~i_sys_reset;
			end
		end

		// Sticky status, write one to clear, set wins
		next_s.flag = (s.flag & ~clr_flag) | expire;
		next_s.irq_ev = (s.irq_ev & ~clr_irq) | (next_s.irq_ev & ~s.irq_ev) |
			(expire & (s.mode == BWT_IRQ || (s.mode == BWT_DUAL && s.stage == ST_COUNT)));
		if (wr_mask) begin
			next_s.mask = i_apb.pwdata[1:0];
		end

		// Read data captured in the setup cycle
		if (setup) begin
			next_s.slverr = ~mapped(i_apb.paddr);
			next_s.prdata = '0;
			case (i_apb.paddr)
				OFS_CTRL: begin
					next_s.prdata[SEL_LO +: SEL_W] = s.sel;
					next_s.prdata[MODE_LO +: 2] = s.mode;
					next_s.prdata[EN_BIT] = s.en;
					next_s.prdata[LINE_BIT] = s.line_sel;
				end
				OFS_STAT: begin
					next_s.prdata[FLAG_BIT] = s.flag;
					next_s.prdata[IRQB_BIT] = s.irq_ev;
					next_s.prdata[STAGE_LO +: 3] = s.stage;
				end
				OFS_MASK: begin
					next_s.prdata[1:0] = s.mask;
				end
				OFS_LEFT: begin
					next_s.prdata[TICK_W-1:0] = last_tick(s.sel) - s.ticks;
				end
				default: begin
					next_s.prdata = '0;
				end
			endcase
		end
	end

	//==============================================================
	// Registers
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			s <= '{
				stage: ST_OFF,
				sel: SEL_RST,
				mode: BWT_TIMER,
				en: 1'b0,
				line_sel: 1'b0,
				flag: 1'b0,
				irq_ev: 1'b0,
				mask: MASK_RST,
				pre: '0,
				ticks: '0,
				hrst: '0,
				line: 1'b0,
				prdata: '0,
				slverr: 1'b0
			};
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	//==============================================================
	// Outputs
	// Zero wait states; a frozen clock enable stretches the access
	assign o_apb.pready  = i_clk_en;
	assign o_apb.prdata  = s.prdata;
	assign o_apb.pslverr = s.slverr & i_apb.psel & i_apb.penable;
	assign o_hard_reset  = (s.stage == ST_HRST);
	assign o_irq         = |({s.irq_ev, s.flag} & s.mask);
	assign o_wdt_line    = s.line;

	//==============================================================
	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	off_until_enabled_a: assert property (
		!s.en |-> (s.stage == ST_OFF) && !o_hard_reset && !s.irq_ev && (s.ticks == '0)
	) else $error("Watchdog active while disabled");

	mode_lock_a: assert property (
		s.en && i_clk_en |=> s.en && (s.mode == $past(s.mode))
	) else $error("Enable or mode changed after enable");

	retrig_reload_a: assert property (
		retrig && i_clk_en && (s.stage == ST_COUNT) |=> (s.ticks == '0) && (s.pre == '0)
	) else $error("Retrigger did not restart countdown");

	expire_flag_a: assert property (
		expire && i_clk_en |=> s.flag
	) else $error("Expiry did not set timeout flag");

	timer_halt_a: assert property (
		expire && i_clk_en && !retrig && (s.mode == BWT_TIMER) |=>
			(s.stage == ST_HALT) && !o_hard_reset && !s.irq_ev ##1 !o_hard_reset
	) else $error("Timer-only expiry did more than flag");

	flag_hold_a: assert property (
		s.flag && !(clr_flag && i_clk_en) |=> s.flag
	) else $error("Timeout flag lost without a clear");

	reset_mode_a: assert property (
		expire && i_clk_en && !retrig && (s.mode == BWT_RESET) |=> o_hard_reset
	) else $error("Reset mode expiry gave no hard reset");

	irq_mode_a: assert property (
		expire && i_clk_en && !retrig && (s.mode == BWT_IRQ) && s.mask[IRQB_BIT] |=>
			o_irq && !o_hard_reset
	) else $error("Interrupt mode expiry wrong");

	dual_first_a: assert property (
		expire && i_clk_en && !retrig && (s.mode == BWT_DUAL) && (s.stage == ST_COUNT) |=>
			(s.stage == ST_SECOND) && (s.ticks == '0) && s.irq_ev && !o_hard_reset
	) else $error("Dual stage first expiry wrong");

	dual_second_a: assert property (
		expire && i_clk_en && !retrig && (s.stage == ST_SECOND) |=> o_hard_reset
	) else $error("Dual stage second expiry gave no reset");

	dual_cancel_a: assert property (
		retrig && i_clk_en && (s.stage == ST_SECOND) |=> (s.stage == ST_COUNT) && !o_hard_reset
	) else $error("Retrigger did not cancel second stage");

	line_first_a: assert property (
		expire && i_clk_en && !retrig && !s.line_sel |=> o_wdt_line
	) else $error("Carrier line not raised at first stage");

	line_hold_a: assert property (
		o_wdt_line && !i_sys_reset && !o_hard_reset |=> o_wdt_line
	) else $error("Carrier line dropped without reset");

	hrst_len_a: assert property (
		$rose(o_hard_reset) && i_clk_en |-> o_hard_reset [*2]
	) else $error("Hard reset pulse too short");

	hrst_count_a: assert property (
		o_hard_reset && (s.hrst != 16'(HRST_CYC - 1)) |=> o_hard_reset
	) else $error("Hard reset pulse ended early");

	hrst_end_a: assert property (
		$fell(o_hard_reset) |-> !o_wdt_line && (s.stage == ST_COUNT)
	) else $error("Carrier line or countdown wrong after hard reset");

	line_second_a: assert property (
		expire && i_clk_en && !retrig && s.line_sel && ((s.mode == BWT_RESET) || (s.stage == ST_SECOND)) |=> o_wdt_line
	) else $error("Carrier line not raised at reset stage");

	line_sysrst_a: assert property (
		i_sys_reset && i_clk_en && !expire |=> !o_wdt_line
	) else $error("Carrier line kept through board reset");

	halt_hold_a: assert property (
		(s.stage == ST_HALT) && s.flag |=> (s.stage == ST_HALT)
	) else $error("Halted watchdog resumed with flag set");

	timer_no_irq_a: assert property (
		(s.mode == BWT_TIMER) |-> !s.irq_ev
	) else $error("Timer-only mode raised an interrupt event");

	dual_irq_a: assert property (
		expire && i_clk_en && !retrig && (s.mode == BWT_DUAL) && (s.stage == ST_COUNT) && s.mask[IRQB_BIT] |=> o_irq
	) else $error("Dual stage first expiry gave no interrupt");

	clk_freeze_a: assert property (
		!i_clk_en |=> $stable(s)
	) else $error("State moved while clock enable low");

endmodule

/* File: verif/bwt_top_tb.sv */
// Self-checking bench for the board watchdog timer
`timescale 1ns/1ps
module bwt_top_tb;
	import bwt_pkg::*;
	//==============================================================
	// Signals
	// Short base tick keeps the tested periods at 8 to 256 cycles
	localparam int BASE  = 8;
	localparam int HRST  = 4;
	localparam int LIMIT = 20000;
	logic         i_core_clk;
	logic         i_reset;
	logic         i_clk_en;
	logic         i_sys_reset;
	bwt_apb_req_t i_apb;
	bwt_apb_rsp_t o_apb;
	logic         o_hard_reset;
	logic         o_irq;
	logic         o_wdt_line;
	logic [2:0]   obs;
	logic [31:0]  rd;
	logic         err;
	int           errors;
	int           check_count;
	int           cycles;
	int           seed;
	int           n;
	int           m;
	int           sel;
	assign obs = {o_wdt_line, o_hard_reset, o_irq};
	bwt_top #(
		.BASE_CYC(BASE),
		.HRST_CYC(HRST)
	) bwt_top_i (
		.i_core_clk  (i_core_clk),
		.i_reset     (i_reset),
		.i_clk_en    (i_clk_en),
		.i_apb       (i_apb),
		.o_apb       (o_apb),
		.i_sys_reset (i_sys_reset),
		.o_hard_reset(o_hard_reset),
		.o_irq       (o_irq),
		.o_wdt_line  (o_wdt_line)
	);
	//==============================================================
	// Clock and hang guard
	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("BAD %0t run did not finish", $time);
			report_and_stop();
		end
	end
	//==============================================================
	// Expectations and bus tasks
	function automatic logic [31:0] ctrl_word(input int s, input bwt_mode_t md, input logic ln);
		return {24'h0, ln, 1'b1, md, s[3:0]};
	endfunction
	function automatic logic [31:0] stat(input int st, input logic [1:0] b);
		return {25'h0, st[2:0], 2'b00, b};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_core_clk);
		i_apb.penable <= 1'b1;
		// Only the bench timeout ends a stuck access
		do begin
			@(posedge i_core_clk);
		end while (o_apb.pready !== 1'b1);
		rd  = o_apb.prdata;
		err = o_apb.pslverr;
		i_apb.psel    <= 1'b0;
		i_apb.penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e, "read");
	endtask
	// Registered outputs are judged one edge after the write lands
	task automatic look(input logic [2:0] e);
		@(posedge i_core_clk);
		chk(32'(obs), 32'(e), "pins");
	endtask
	task automatic wait_hi(input int b, output int cnt);
		cnt = 0;
		while (obs[b] !== 1'b1 && cnt < 1000) begin
			@(posedge i_core_clk);
			cnt++;
		end
	endtask
	task automatic power_cycle(input int len);
		i_reset <= 1'b1;
		repeat (len) @(posedge i_core_clk);
		i_reset <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	//==============================================================
	// Main sequence
	initial begin
		seed        = 41;
		errors      = 0;
		check_count = 0;
		cycles      = 0;
		i_reset     = 1'b1;
		i_clk_en    = 1'b1;
		i_sys_reset = 1'b0;
		i_apb       = '0;
		power_cycle(20);
		rdchk(OFS_CTRL, 32'h0);
		rdchk(OFS_STAT, 32'h0);
		rdchk(OFS_MASK, {30'h0, MASK_RST});
		apb(1'b0, 12'h010, 32'h0);
		chk(32'(err), 32'h1, "slverr");
		wr(OFS_CTRL, 32'h3);
		rdchk(OFS_LEFT, 32'((1 << 3) - 1));
		repeat (3 * BASE) @(posedge i_core_clk);
		look(3'b000);
		rdchk(OFS_LEFT, 32'((1 << 3) - 1));
		// Timer mode with random service gaps, all shorter than one period
		wr(OFS_CTRL, ctrl_word(0, BWT_TIMER, 1'b0));
		repeat (8) begin
			repeat ({$random(seed)} % 3) @(posedge i_core_clk);
			wr(OFS_CTRL, ctrl_word(0, BWT_TIMER, 1'b0) | 32'h100);
		end
		rdchk(OFS_STAT, stat(1, 2'b00));
		wr(OFS_CTRL, 32'h10);
		rdchk(OFS_CTRL, ctrl_word(0, BWT_TIMER, 1'b0));
		repeat (2 * BASE) @(posedge i_core_clk);
		rdchk(OFS_STAT, stat(3, 2'b01));
		look(3'b100);
		wr(OFS_CTRL, ctrl_word(0, BWT_TIMER, 1'b0) | 32'h100);
		rdchk(OFS_STAT, stat(3, 2'b01));
		wr(OFS_STAT, 32'h1);
		wr(OFS_CTRL, ctrl_word(0, BWT_TIMER, 1'b0) | 32'h100);
		rdchk(OFS_STAT, stat(1, 2'b00));
		look(3'b100);
		i_sys_reset <= 1'b1;
		@(posedge i_core_clk);
		i_sys_reset <= 1'b0;
		look(3'b000);
		// Reset mode, line tied to the hard reset stage
		power_cycle(2);
		rdchk(OFS_STAT, 32'h0);
		wr(OFS_CTRL, ctrl_word(0, BWT_RESET, 1'b1));
		wait_hi(1, n);
		m = 0;
		while (o_hard_reset === 1'b1 && m < 100) begin
			m++;
			if (m == 2) chk(32'(obs[2:1]), 32'h3, "pins");
			@(posedge i_core_clk);
		end
		chk(32'(m), 32'(HRST), "pulse");
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd & 32'h71, 32'h11, "flag");
		chk(32'(obs[2:1]), 32'h0, "pins");
		// Interrupt mode, then mask and clear
		power_cycle(2);
		rdchk(OFS_STAT, 32'h0);
		wr(OFS_CTRL, ctrl_word(1, BWT_IRQ, 1'b0));
		wait_hi(0, n);
		repeat (4 * BASE) @(posedge i_core_clk);
		look(3'b101);
		rdchk(OFS_STAT, stat(3, 2'b11));
		wr(OFS_MASK, 32'h0);
		look(3'b100);
		wr(OFS_MASK, 32'h3);
		wr(OFS_STAT, 32'h2);
		look(3'b101);
		wr(OFS_STAT, 32'h1);
		look(3'b100);
		// Dual stage: second stage follows after exactly one period
		for (int k = 0; k < 5; k++) begin
			sel = (k < 4) ? k : 4 + {$random(seed)} % 2;
			power_cycle(2);
			wr(OFS_CTRL, ctrl_word(sel, BWT_DUAL, 1'b0));
			wait_hi(0, n);
			// A frozen clock enable stretches the second stage by exactly the gap
			i_clk_en <= 1'b0;
			repeat (1 + {$random(seed)} % 3) @(posedge i_core_clk);
			i_clk_en <= 1'b1;
			wait_hi(1, m);
			chk(32'(m), 32'(BASE << sel), "stage gap");
		end
		power_cycle(2);
		wr(OFS_CTRL, ctrl_word(1, BWT_DUAL, 1'b1));
		wait_hi(0, n);
		rdchk(OFS_STAT, stat(2, 2'b11));
		wr(OFS_CTRL, ctrl_word(1, BWT_DUAL, 1'b1) | 32'h100);
		rdchk(OFS_STAT, stat(1, 2'b11));
		look(3'b001);
		report_and_stop();
	end
endmodule
